// [rtl/cdic_top.sv]
// Doze and idle power control: register file, power state and CPU cycle throttle.
// Assumes the core gives one-cycle pulses for sleep, interrupt entry and return.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Low-power regulator select applies during sleep
// - Reserved regulator bit reads one always
// - Idle select chooses idle versus full sleep
// - Throttle enable gates CPU cycles by ratio
// - Interrupt entry clears throttle when recover set
// - Return sets throttle when throttle-on-return set
// - Ratio field selects 1:4 up to 1:256
// - Debug forces full speed, bit kept
// - Throttle bit writable, hardware set/clear too
// - Enabled interrupt ends idle, idle select kept
// - Waking interrupt restores full speed when recover
module cdic_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic periph_cycle, // Peripheral instruction cycle strobe
   input wire logic sleep_exec, // Sleep instruction pulse
   input wire logic irq_pending, // Enabled interrupt with flag set
   input wire logic irq_entry, // ISR entry pulse
   input wire logic return_from_irq, // Return instruction pulse
   input wire logic debug_session, // Debug session active level
   input wire logic wake_event, // Non-interrupt wake (watchdog)
   output logic cpu_cycle_en, // CPU advance enable, one cycle
   output logic periph_clk_en, // Peripheral clocks running
   output logic cpu_clk_en, // CPU clock running
   output logic regulator_lowpower // Regulator low-power state now
);
   import cdic_pkg::*;

   // ********************************************************
   // Registers
   // ********************************************************
   logic regulator_lowpower_select_r; // Stored regulator mode
   logic idle_select_r; // Stored idle choice
   logic throttle_enable_r; // Stored throttle bit
   logic recover_on_irq_r; // Auto clear on entry
   logic throttle_on_return_r; // Auto set on return
   logic [2:0] ratio_r; // Throttle ratio code
   cdic_state_e state_r; // Power state
   logic [7:0] ratio_cnt_r; // Peripheral cycle counter

   // ********************************************************
   // Bus slave state
   // ********************************************************
   logic aw_held_r; // Write address captured
   logic w_held_r; // Write data captured
   logic [7:0] awaddr_r; // Captured write address
   logic [31:0] wdata_r; // Captured write data
   logic [3:0] wstrb_r; // Captured strobes
   logic wr_fire; // Both halves present
   logic [7:0] throttle_rd; // Throttle register image
   logic [7:0] regulator_rd; // Regulator register image
   logic [7:0] status_rd; // Status image

   // Ratio code to period; code 000 is treated as 1:2 (undefined)
   function automatic logic [7:0] ratio_last(input logic [2:0] code);
      ratio_last = 8'(({1'b0, 8'h01} << ({1'b0, code} + 4'h1)) - 9'h001);
   endfunction

   assign throttle_rd = {idle_select_r, throttle_enable_r, recover_on_irq_r,
                         throttle_on_return_r, 1'b0, ratio_r};
   assign regulator_rd = {6'h00, regulator_lowpower_select_r, 1'b1};
   assign status_rd = {4'h0, debug_session, cpu_clk_en, state_r};
   assign wr_fire = (aw_held_r || s_axi_awvalid) && (w_held_r || s_axi_wvalid)
                    && !s_axi_bvalid;

   // ********************************************************
   // Write channel acceptance
   // ********************************************************
   // Ready low once a half is held, so each half is taken once per write
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // Capture address and data in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end else if (wr_fire) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
         end
      end
   end

   // Effective write address and data for the firing cycle
   logic [7:0] wa; // Write address in use
   logic [7:0] wd; // Low byte of write data
   logic wb; // Low byte lane enabled
   assign wa = aw_held_r ? awaddr_r : s_axi_awaddr;
   assign wd = w_held_r ? wdata_r[7:0] : s_axi_wdata[7:0];
   assign wb = w_held_r ? wstrb_r[0] : s_axi_wstrb[0];

   // Write response, error on unmapped address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CDIC_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         if (wa[7:2] == CDIC_REG_REGULATOR[7:2] || wa[7:2] == CDIC_REG_THROTTLE[7:2]) begin
            s_axi_bresp <= CDIC_RESP_OKAY;
         end else if (wa[7:2] == CDIC_REG_STATUS[7:2]) begin
            s_axi_bresp <= CDIC_RESP_OKAY; // Read only, write ignored
         end else begin
            s_axi_bresp <= CDIC_RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read data, error on unmapped address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= CDIC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= CDIC_RESP_OKAY;
         if (s_axi_araddr[7:2] == CDIC_REG_REGULATOR[7:2]) begin
            s_axi_rdata <= {24'h000000, regulator_rd};
         end else if (s_axi_araddr[7:2] == CDIC_REG_THROTTLE[7:2]) begin
            s_axi_rdata <= {24'h000000, throttle_rd};
         end else if (s_axi_araddr[7:2] == CDIC_REG_STATUS[7:2]) begin
            s_axi_rdata <= {24'h000000, status_rd};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= CDIC_RESP_SLVERR;
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ********************************************************
   // Regulator control register
   // ********************************************************
   // Reserved bit is not stored; it is constant one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         regulator_lowpower_select_r <= CDIC_REGULATOR_RST[CDIC_REG_LP_BIT];
      end else if (wr_fire && wb && wa[7:2] == CDIC_REG_REGULATOR[7:2]) begin
         regulator_lowpower_select_r <= wd[CDIC_REG_LP_BIT];
      end
   end

   // ********************************************************
   // Throttle control register
   // ********************************************************
   logic throttle_nxt; // Next throttle enable
   always_comb begin
      throttle_nxt = throttle_enable_r;
      if (wr_fire && wb && wa[7:2] == CDIC_REG_THROTTLE[7:2]) begin
         throttle_nxt = wd[CDIC_THR_EN_BIT];
      end
      // Hardware events come after software so a clash keeps the event
      if (irq_entry && recover_on_irq_r) begin
         throttle_nxt = 1'b0;
      end else if (return_from_irq && throttle_on_return_r) begin
         throttle_nxt = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         throttle_enable_r <= CDIC_THROTTLE_RST[CDIC_THR_EN_BIT];
      end else begin
         throttle_enable_r <= throttle_nxt;
      end
   end

   // Other fields change only by software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idle_select_r <= CDIC_THROTTLE_RST[CDIC_THR_IDLE_BIT];
         recover_on_irq_r <= CDIC_THROTTLE_RST[CDIC_THR_ROI_BIT];
         throttle_on_return_r <= CDIC_THROTTLE_RST[CDIC_THR_DOE_BIT];
         ratio_r <= CDIC_THROTTLE_RST[2:0];
      end else if (wr_fire && wb && wa[7:2] == CDIC_REG_THROTTLE[7:2]) begin
         idle_select_r <= wd[CDIC_THR_IDLE_BIT];
         recover_on_irq_r <= wd[CDIC_THR_ROI_BIT];
         throttle_on_return_r <= wd[CDIC_THR_DOE_BIT];
         ratio_r <= wd[2:0];
      end
   end

   // ********************************************************
   // Power state
   // ********************************************************
   // Interrupt wakes even with global enable off; RECOVER_ON_IRQ acts via irq_entry
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= CDIC_RUN;
      end else begin
         case (state_r)
            CDIC_RUN: begin
               // Pending interrupt turns sleep into a no-op
               if (sleep_exec && !irq_pending) begin
                  state_r <= idle_select_r ? CDIC_IDLE : CDIC_SLEEP;
               end
            end
            CDIC_IDLE: begin
               if (irq_pending || wake_event) begin
                  state_r <= CDIC_RUN;
               end
            end
            CDIC_SLEEP: begin
               if (irq_pending || wake_event) begin
                  state_r <= CDIC_RUN;
               end
            end
            default: begin
               state_r <= CDIC_RUN;
            end
         endcase
      end
   end

   assign cpu_clk_en = (state_r == CDIC_RUN);
   assign periph_clk_en = (state_r != CDIC_SLEEP);
   assign regulator_lowpower = (state_r == CDIC_SLEEP) && regulator_lowpower_select_r;

   // ********************************************************
   // Cycle throttle
   // ********************************************************
   // Counter only moves on peripheral cycles, so peripherals never stall
   logic throttling; // Throttle in force now
   assign throttling = throttle_enable_r && !debug_session;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ratio_cnt_r <= CDIC_RATIO_CNT_RST;
      end else if (!throttling) begin
         ratio_cnt_r <= CDIC_RATIO_CNT_RST;
      end else if (periph_cycle && cpu_clk_en) begin
         if (ratio_cnt_r >= ratio_last(ratio_r)) begin
            ratio_cnt_r <= CDIC_RATIO_CNT_RST;
         end else begin
            ratio_cnt_r <= ratio_cnt_r + 8'h01;
         end
      end
   end

   // Handshake-style enable; combinational by design
   assign cpu_cycle_en = periph_cycle && cpu_clk_en &&
                         (!throttling || ratio_cnt_r == CDIC_RATIO_CNT_RST);

   // ********************************************************
   // Assertions
   // ********************************************************
   property p_lowpower;
      @(posedge aclk) disable iff (!aresetn)
      regulator_lowpower |-> (state_r == CDIC_SLEEP && regulator_lowpower_select_r);
   endproperty
   a_lowpower: assert property (p_lowpower) else $error("low power outside sleep");

   property p_reserved;
      @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && $past(s_axi_araddr[7:2]) == 6'h00 && $rose(s_axi_rvalid)
      |-> s_axi_rdata[0];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit read zero");

   property p_idle_enter;
      @(posedge aclk) disable iff (!aresetn)
      (state_r == CDIC_RUN && sleep_exec && !irq_pending && idle_select_r)
      |=> (state_r == CDIC_IDLE && periph_clk_en && !cpu_clk_en);
   endproperty
   a_idle_enter: assert property (p_idle_enter) else $error("idle not entered");

   property p_full_speed;
      @(posedge aclk) disable iff (!aresetn)
      (!throttle_enable_r && periph_cycle && cpu_clk_en) |-> cpu_cycle_en;
   endproperty
   a_full_speed: assert property (p_full_speed) else $error("cycle lost at full speed");

   property p_roi;
      @(posedge aclk) disable iff (!aresetn)
      (irq_entry && recover_on_irq_r) |=> !throttle_enable_r;
   endproperty
   a_roi: assert property (p_roi) else $error("entry did not clear throttle");

   property p_doe;
      @(posedge aclk) disable iff (!aresetn)
      (return_from_irq && throttle_on_return_r && !irq_entry) |=> throttle_enable_r;
   endproperty
   a_doe: assert property (p_doe) else $error("return did not set throttle");

   property p_ratio4;
      @(posedge aclk) disable iff (!aresetn)
      (ratio_r == 3'h1 && throttling && cpu_cycle_en) |=> !cpu_cycle_en [*3];
   endproperty
   a_ratio4: assert property (p_ratio4) else $error("ratio 1:4 violated");

   property p_debug;
      @(posedge aclk) disable iff (!aresetn)
      (debug_session && periph_cycle && cpu_clk_en) |-> cpu_cycle_en;
   endproperty
   a_debug: assert property (p_debug) else $error("debug not full speed");

   property p_hold;
      @(posedge aclk) disable iff (!aresetn)
      (!wr_fire && !irq_entry && !return_from_irq) |=> $stable(throttle_enable_r);
   endproperty
   a_hold: assert property (p_hold) else $error("throttle changed unprompted");

   property p_idle_exit;
      @(posedge aclk) disable iff (!aresetn)
      (state_r == CDIC_IDLE && irq_pending) |=> (state_r == CDIC_RUN && $stable(idle_select_r));
   endproperty
   a_idle_exit: assert property (p_idle_exit) else $error("idle exit wrong");

   property p_periph;
      @(posedge aclk) disable iff (!aresetn)
      (state_r != CDIC_SLEEP) |-> periph_clk_en;
   endproperty
   a_periph: assert property (p_periph) else $error("peripherals stopped");

   c_idle: cover property (@(posedge aclk) disable iff (!aresetn)
      state_r == CDIC_IDLE ##1 state_r == CDIC_RUN);
   c_sleep: cover property (@(posedge aclk) disable iff (!aresetn) state_r == CDIC_SLEEP);
   c_throttle: cover property (@(posedge aclk) disable iff (!aresetn)
      throttling && cpu_cycle_en);
   c_roi: cover property (@(posedge aclk) disable iff (!aresetn)
      irq_entry && recover_on_irq_r && throttle_enable_r);
endmodule
`default_nettype wire

// [rtl/cdic_pkg.sv]
// Constants shared by the doze and idle power control block.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package cdic_pkg;
   // ********************************************************
   // Register map (byte addresses)
   // ********************************************************
   localparam logic [7:0] CDIC_REG_REGULATOR = 8'h00; // Regulator power control
   localparam logic [7:0] CDIC_REG_THROTTLE = 8'h04; // Throttle and idle control
   localparam logic [7:0] CDIC_REG_STATUS = 8'h08; // Live power state, read only
   // ********************************************************
   // Field positions
   // ********************************************************
   localparam int CDIC_REG_LP_BIT = 1; // Low-power regulator select
   localparam int CDIC_REG_RSV_BIT = 0; // Reserved, reads one
   localparam int CDIC_THR_IDLE_BIT = 7; // Idle select
   localparam int CDIC_THR_EN_BIT = 6; // Throttle enable
   localparam int CDIC_THR_ROI_BIT = 5; // Recover on interrupt
   localparam int CDIC_THR_DOE_BIT = 4; // Throttle on return
   // ********************************************************
   // Reset values
   // ********************************************************
   localparam logic [7:0] CDIC_REGULATOR_RST = 8'h01;
   localparam logic [7:0] CDIC_THROTTLE_RST = 8'h00;
   localparam logic [7:0] CDIC_RATIO_CNT_RST = 8'h00;
   // ********************************************************
   // Power states
   // ********************************************************
   typedef enum logic [1:0] {
      CDIC_RUN = 2'b00,
      CDIC_IDLE = 2'b01,
      CDIC_SLEEP = 2'b10
   } cdic_state_e;
   localparam logic [1:0] CDIC_RESP_OKAY = 2'b00;
   localparam logic [1:0] CDIC_RESP_SLVERR = 2'b10;
endpackage

// [tb/cdic_top_bench.sv]
// Self-checking bench for the doze and idle power control block.
// Assumes the design's own assertions run alongside; drives all ports directly.
`timescale 1ns/1ps
`default_nettype none
module cdic_top_bench;
   import cdic_pkg::*;
   // ****************************************
   // Signals
   // ****************************************
   logic aclk, aresetn; // Clock and active-low reset
   logic [7:0] awaddr, araddr; // Bus addresses
   logic awvalid, wvalid, bready, arvalid, rready; // Master handshakes
   logic awready, wready, bvalid, arready, rvalid; // Slave handshakes
   logic [31:0] wdata, rdata; // Bus data
   logic [3:0] wstrb; // Byte strobes
   logic [1:0] bresp, rresp; // Response codes
   logic periph, irq, dbg; // Peripheral strobe, pending level, debug level
   logic [3:0] ev; // Pulses: wake, return, entry, sleep
   logic cpu_en, per_en, cpu_clk, lp; // Observed power outputs
   logic [31:0] d; // Scratch read data
   logic [1:0] r; // Scratch response
   int n_fail, checks, cyc, cnt; // Counters
   // ****************************************
   // Device under test
   // ****************************************
   cdic_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .periph_cycle(periph), .sleep_exec(ev[0]),
      .irq_pending(irq), .irq_entry(ev[1]), .return_from_irq(ev[2]),
      .debug_session(dbg), .wake_event(ev[3]), .cpu_cycle_en(cpu_en),
      .periph_clk_en(per_en), .cpu_clk_en(cpu_clk), .regulator_lowpower(lp));
   // ****************************************
   // Clock and hang guard
   // ****************************************
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // Whole run is a few thousand cycles; ceiling leaves wide margin
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         test_done();
      end
   end
   // ****************************************
   // Tasks
   // ****************************************
   // Compare any result, widened to a word
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks = checks + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Write one word; address and data halves released as each is taken
   task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
      logic aw_t, w_t, aw_d, w_d;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_d = 1'b0;
      w_d = 1'b0;
      while (!(aw_d && w_d)) begin
         @(negedge aclk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         @(posedge aclk);
         if (aw_t) begin
            awvalid <= 1'b0;
            aw_d = 1'b1;
         end
         if (w_t) begin
            wvalid <= 1'b0;
            w_d = 1'b1;
         end
      end
      // Hold bready until the response is seen at an edge
      do @(negedge aclk); while (bvalid !== 1'b1);
      @(posedge aclk);
      bready <= 1'b0;
      chk("bresp", {30'h0, CDIC_RESP_OKAY}, {30'h0, bresp});
   endtask
   // Read one word and its response code
   task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      logic t;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge aclk);
         t = arvalid && arready;
         @(posedge aclk);
      end while (!t);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) begin
         @(negedge aclk);
         if (rvalid !== 1'b1) @(posedge aclk);
      end
      // Data taken at the edge where rvalid and rready meet
      @(posedge aclk);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // Read a register and compare with the expected value
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
      axi_read(a, d, r);
      chk(nm, exp, d);
   endtask
   // One-cycle core strobe; ends once the effect has landed
   task automatic pulse(input logic [3:0] k);
      @(posedge aclk);
      ev <= k;
      @(posedge aclk);
      ev <= 4'h0;
      @(negedge aclk);
   endtask
   // Pending level for one cycle, as a waking interrupt
   task automatic irq_wake();
      @(posedge aclk);
      irq <= 1'b1;
      @(posedge aclk);
      irq <= 1'b0;
      @(negedge aclk);
   endtask
   // Power outputs as a group
   task automatic chk_pwr(input logic c, input logic p, input logic l);
      chk("cpu_clk_en", {31'h0, c}, {31'h0, cpu_clk});
      chk("periph_clk_en", {31'h0, p}, {31'h0, per_en});
      chk("regulator_lowpower", {31'h0, l}, {31'h0, lp});
   endtask
   // Count CPU advances over n peripheral strobes
   task automatic run_cpu(input int n);
      cnt = 0;
      for (int i = 0; i < n; i++) begin
         @(posedge aclk);
         periph <= 1'b1;
         @(negedge aclk);
         if (cpu_en === 1'b1) cnt = cnt + 1;
         @(posedge aclk);
         periph <= 1'b0;
      end
   endtask
   // Single place where the run ends
   task automatic test_done();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, periph, irq, dbg} = '0;
      {awaddr, araddr, wdata, wstrb, ev} = '0;
      {n_fail, checks, cyc} = '0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values, status and an unmapped place
      rd_chk("regulator", CDIC_REG_REGULATOR, 32'h01);
      rd_chk("throttle", CDIC_REG_THROTTLE, 32'h00);
      rd_chk("status", CDIC_REG_STATUS, 32'h04);
      axi_read(8'h0C, d, r);
      chk("unmapped_resp", {30'h0, CDIC_RESP_SLVERR}, {30'h0, r});
      chk("unmapped_data", 32'h0, d);
      // Software keeps the reserved bit set on every write
      axi_write(CDIC_REG_REGULATOR, 32'h1);
      rd_chk("regulator", CDIC_REG_REGULATOR, 32'h01);
      axi_write(CDIC_REG_REGULATOR, 32'h3);
      rd_chk("regulator", CDIC_REG_REGULATOR, 32'h03);
      // Full sleep with low-power regulator, watchdog wake
      pulse(4'h1);
      chk_pwr(1'b0, 1'b0, 1'b1);
      pulse(4'h8);
      chk_pwr(1'b1, 1'b1, 1'b0);
      // Normal regulator in sleep, interrupt wake
      axi_write(CDIC_REG_REGULATOR, 32'h1);
      pulse(4'h1);
      chk_pwr(1'b0, 1'b0, 1'b0);
      irq_wake();
      chk_pwr(1'b1, 1'b1, 1'b0);
      // Pending interrupt turns sleep into a no-op
      @(posedge aclk);
      irq <= 1'b1;
      pulse(4'h1);
      chk_pwr(1'b1, 1'b1, 1'b0);
      @(posedge aclk);
      irq <= 1'b0;
      // Idle: CPU stops, peripherals run, select kept after wake
      axi_write(CDIC_REG_THROTTLE, 32'h80);
      pulse(4'h1);
      chk_pwr(1'b0, 1'b1, 1'b0);
      rd_chk("status", CDIC_REG_STATUS, 32'h01);
      irq_wake();
      chk_pwr(1'b1, 1'b1, 1'b0);
      rd_chk("throttle", CDIC_REG_THROTTLE, 32'h80);
      // Ratio codes 1 to 7: two CPU advances over two ratio periods
      for (int c = 1; c < 8; c++) begin
         axi_write(CDIC_REG_THROTTLE, 32'h40 | c);
         run_cpu(2 * (1 << (c + 1)));
         chk("cpu_cycles", 32'd2, cnt);
      end
      // Throttle off runs every cycle
      axi_write(CDIC_REG_THROTTLE, 32'h01);
      run_cpu(8);
      chk("cpu_cycles", 32'd8, cnt);
      // Debug overrides throttle, stored bit kept
      axi_write(CDIC_REG_THROTTLE, 32'h41);
      dbg <= 1'b1;
      run_cpu(8);
      chk("cpu_cycles", 32'd8, cnt);
      rd_chk("throttle", CDIC_REG_THROTTLE, 32'h41);
      rd_chk("status", CDIC_REG_STATUS, 32'h0C);
      dbg <= 1'b0;
      // Interrupt entry with and without recovery
      axi_write(CDIC_REG_THROTTLE, 32'h61);
      pulse(4'h2);
      rd_chk("throttle", CDIC_REG_THROTTLE, 32'h21);
      axi_write(CDIC_REG_THROTTLE, 32'h41);
      pulse(4'h2);
      rd_chk("throttle", CDIC_REG_THROTTLE, 32'h41);
      // Return with and without re-throttle
      axi_write(CDIC_REG_THROTTLE, 32'h11);
      pulse(4'h4);
      rd_chk("throttle", CDIC_REG_THROTTLE, 32'h51);
      axi_write(CDIC_REG_THROTTLE, 32'h01);
      pulse(4'h4);
      rd_chk("throttle", CDIC_REG_THROTTLE, 32'h01);
      // Waking interrupt from idle restores full speed
      axi_write(CDIC_REG_THROTTLE, 32'hE1);
      pulse(4'h1);
      chk_pwr(1'b0, 1'b1, 1'b0);
      irq_wake();
      pulse(4'h2);
      chk_pwr(1'b1, 1'b1, 1'b0);
      rd_chk("throttle", CDIC_REG_THROTTLE, 32'hA1);
      test_done();
   end
endmodule
`default_nettype wire
